// ---- hw/sensor_mode_sequencer_cfg.svh ----
// offsets, field positions, reset values and timing constants of the sensor mode sequencer
`ifndef SENSOR_MODE_SEQUENCER_CFG_SVH
`define SENSOR_MODE_SEQUENCER_CFG_SVH

// register byte offsets
`define OFS_ID          8'h00
`define OFS_RESET       8'h04
`define OFS_CTRL_HUM    8'h08
`define OFS_STATUS      8'h0c
`define OFS_CTRL_MEAS   8'h10
`define OFS_CONFIG      8'h14
`define OFS_PRESS       8'h18
`define OFS_TEMP        8'h1c
`define OFS_HUM         8'h20

// field positions
`define MEAS_OSRS_T     7:5
`define MEAS_OSRS_P     4:2
`define MEAS_MODE       1:0
`define CFG_STANDBY     7:5
`define CFG_FILTER      4:2
`define HUM_OSRS_H      2:0
`define STATUS_BUSY     3

// values
`define SOFT_RESET_CMD  8'hb6
`define CHIP_ID_VAL     8'h5a
`define MODE_SLEEP      2'h0
`define MODE_NORMAL     2'h3
`define SKIP_TP         20'h80000
`define SKIP_H          16'h8000
`define CTRL_RESET      8'h00
`define SAMPLE_BITS     5'h14

// standby counts in half-millisecond ticks, per selection code
`define SB_TICKS_0      12'h001
`define SB_TICKS_1      12'h07d
`define SB_TICKS_2      12'h0fa
`define SB_TICKS_3      12'h1f4
`define SB_TICKS_4      12'h3e8
`define SB_TICKS_5      12'h7d0
`define SB_TICKS_6      12'h014
`define SB_TICKS_7      12'h028

// timing
`define CLK_FREQ_KHZ    20000
`define SB_TICK_US      500
`define SB_TICK_CYCLES  ((`SB_TICK_US * `CLK_FREQ_KHZ) / 1000)

`endif

// ---- hw/sensor_mode_sequencer_pkg.sv ----
// types shared by the sensor mode sequencer, its assertions, the front end model and the bench
package sensor_mode_sequencer_pkg;

    // measurement sequencer states
    typedef enum logic [2:0] {
        ST_SLEEP   = 3'b000,
        ST_START   = 3'b001,
        ST_WAIT    = 3'b010,
        ST_STANDBY = 3'b011
    } seq_state_e;

    // one conversion request towards the front end
    typedef struct packed {
        logic       req;
        logic [1:0] chan;
        logic [2:0] osrs;
    } conv_req_s;

    // latched address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_phase_s;

endpackage

// ---- hw/sample_link_rx.sv ----
// serial receiver for one conversion word from the analog front end
`timescale 1ns/1ps
`include "sensor_mode_sequencer_cfg.svh"
module sample_link_rx (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clear,
    // control
    input  wire logic        start,
    output logic             done_q,
    output logic [19:0]      word_q,
    // link pins
    input  wire logic        link_sclk,
    input  wire logic        link_sdata
);

    logic        sclk_m_q, sclk_s_q, sclk_p_q;
    logic        data_m_q, data_s_q;
    logic        busy_q;
    logic [4:0]  cnt_q;
    logic [19:0] shift_q;
    wire         sclk_rise = sclk_s_q & ~sclk_p_q;
    wire         last_bit  = busy_q && sclk_rise && (cnt_q == `SAMPLE_BITS - 5'h01);

    // two-stage synchronisers; the link clock keeps a third stage for its rising edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {sclk_m_q, sclk_s_q, sclk_p_q} <= 3'h0;
            {data_m_q, data_s_q}           <= 2'h0;
        end else begin
            {sclk_m_q, sclk_s_q, sclk_p_q} <= {link_sclk, sclk_m_q, sclk_s_q};
            {data_m_q, data_s_q}           <= {link_sdata, data_m_q};
        end
    end

    // msb first, sampled on each rising link clock edge while busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q  <= 1'b0;
            cnt_q   <= 5'h00;
            shift_q <= 20'h00000;
            done_q  <= 1'b0;
            word_q  <= 20'h00000;
        end else if (clear) begin
            busy_q <= 1'b0;
            cnt_q  <= 5'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= last_bit;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q  <= 5'h00;
            end else if (busy_q && sclk_rise) begin
                shift_q <= {shift_q[18:0], data_s_q};
                cnt_q   <= cnt_q + 5'h01;
                if (last_bit) begin
                    busy_q <= 1'b0;
                    word_q <= {shift_q[18:0], data_s_q};
                end
            end
        end
    end

endmodule // sample_link_rx

// ---- hw/sensor_mode_sequencer.sv ----
// sensor mode sequencer: power/soft reset, modes, measurement order, filter, ahb-lite registers
`timescale 1ns/1ps
`include "sensor_mode_sequencer_cfg.svh"
module sensor_mode_sequencer #(
    parameter int unsigned SB_TICK_CYCLES = `SB_TICK_CYCLES,
    parameter logic [7:0]  CHIP_ID        = `CHIP_ID_VAL  // arbitrary value
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata_q,
    output logic             hreadyout_q,
    output logic             hresp_q,
    // supply monitors
    input  wire logic        core_pwr_ok,
    input  wire logic        io_pwr_ok,
    // front end link
    output sensor_mode_sequencer_pkg::conv_req_s conv_q,
    output logic             link_oe_n_q,
    input  wire logic        link_sclk,
    input  wire logic        link_sdata
);

    // synchronised supply flags
    logic       core_m_q, core_s_q, io_m_q, io_s_q;
    logic       por_done_q;
    logic       soft_rst_q;
    // registers
    logic [7:0] ctrl_meas_q, ctrl_hum_q, config_q;
    logic [1:0] mode_q, pend_mode_q;
    logic       pend_q;
    logic [19:0] temp_q, press_q, temp_mem_q, press_mem_q;
    logic [15:0] hum_q;
    logic [1:0] filt_init_q;  // seeded flags: bit 0 temperature, bit 1 pressure
    // sequencer
    sensor_mode_sequencer_pkg::seq_state_e state_q;
    sensor_mode_sequencer_pkg::ahb_phase_s ph_q;
    logic [1:0]  ch_q;
    logic [11:0] sb_cnt_q;
    logic [31:0] div_q;
    logic        rx_done;
    logic [19:0] rx_word;

    // logic reset: held until both supplies good, or soft reset
    wire logic_rst = !por_done_q || soft_rst_q;

    // standby ticks for a selection code
    function automatic logic [11:0] sb_ticks(input logic [2:0] sel);
        unique case (sel)
            3'h0: return `SB_TICKS_0;
            3'h1: return `SB_TICKS_1;
            3'h2: return `SB_TICKS_2;
            3'h3: return `SB_TICKS_3;
            3'h4: return `SB_TICKS_4;
            3'h5: return `SB_TICKS_5;
            3'h6: return `SB_TICKS_6;
            3'h7: return `SB_TICKS_7;
        endcase
    endfunction

    // one iir step: old + (adc - old) / 2^k; k of zero passes adc through
    function automatic logic [19:0] iir_step(input logic [19:0] old, input logic [19:0] adc,
                                             input logic [2:0] k);
        logic [24:0] acc;
        acc = ({5'h00, old} << k) - {5'h00, old} + {5'h00, adc};
        return 20'(acc >> k);
    endfunction

    // filter shift from filter code; codes above four clamp to sixteen
    wire [2:0] filt_k = (config_q[`CFG_FILTER] > 3'h4) ? 3'h4 : config_q[`CFG_FILTER];

    // bus decode
    wire        addr_take  = hsel && htrans[1] && hready;
    wire        wr_en      = ph_q.valid && ph_q.write;
    wire        wr_meas    = wr_en && (ph_q.addr == `OFS_CTRL_MEAS);
    wire        wr_hum     = wr_en && (ph_q.addr == `OFS_CTRL_HUM);
    wire        wr_cfg     = wr_en && (ph_q.addr == `OFS_CONFIG);
    wire        wr_reset   = wr_en && (ph_q.addr == `OFS_RESET) && (hwdata[7:0] == `SOFT_RESET_CMD);
    wire        measuring  = (state_q == sensor_mode_sequencer_pkg::ST_START) ||
                             (state_q == sensor_mode_sequencer_pkg::ST_WAIT);
    wire        meas_take  = wr_meas && !pend_q;
    wire        hum_take   = wr_hum && !pend_q;
    wire [1:0]  wr_mode    = hwdata[`MEAS_MODE];

    // read mux, address taken from the address phase
    wire [7:0]  rd_addr    = haddr[7:0];
    logic [31:0] rd_data;
    assign rd_data = (rd_addr == `OFS_ID)        ? {24'h000000, CHIP_ID} :
                     (rd_addr == `OFS_CTRL_HUM)  ? {24'h000000, ctrl_hum_q} :
                     (rd_addr == `OFS_STATUS)    ? {28'h0000000, measuring, 3'h0} :
                     (rd_addr == `OFS_CTRL_MEAS) ? {24'h000000, ctrl_meas_q[7:2], mode_q} :
                     (rd_addr == `OFS_CONFIG)    ? {24'h000000, config_q} :
                     (rd_addr == `OFS_PRESS)     ? {12'h000, press_q} :
                     (rd_addr == `OFS_TEMP)      ? {12'h000, temp_q} :
                     (rd_addr == `OFS_HUM)       ? {16'h0000, hum_q} :
                                                   32'h00000000;

    // channel settings of the current step
    wire [2:0]  osrs_cur   = (ch_q == 2'h0) ? ctrl_meas_q[`MEAS_OSRS_T] :
                             (ch_q == 2'h1) ? ctrl_meas_q[`MEAS_OSRS_P] :
                                              ctrl_hum_q[`HUM_OSRS_H];
    wire        last_ch    = (ch_q == 2'h2);
    wire        step_done  = ((state_q == sensor_mode_sequencer_pkg::ST_START) && (osrs_cur == 3'h0)) ||
                             ((state_q == sensor_mode_sequencer_pkg::ST_WAIT) && rx_done);
    wire        meas_end   = step_done && last_ch;
    wire        rx_start   = (state_q == sensor_mode_sequencer_pkg::ST_START) && (osrs_cur != 3'h0);
    // mode in force once the measurement period ends
    wire [1:0]  end_mode   = pend_q ? pend_mode_q :
                             (mode_q == `MODE_NORMAL) ? mode_q : `MODE_SLEEP;
    wire [19:0] t_filt     = filt_init_q[0] ? iir_step(temp_mem_q, rx_word, filt_k) : rx_word;
    wire [19:0] p_filt     = filt_init_q[1] ? iir_step(press_mem_q, rx_word, filt_k) : rx_word;
    wire        sb_tick    = (div_q == SB_TICK_CYCLES - 1);

    // supply monitor synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {core_m_q, core_s_q, io_m_q, io_s_q} <= 4'h0;
        end else begin
            {core_m_q, core_s_q} <= {core_pwr_ok, core_m_q};
            {io_m_q, io_s_q}     <= {io_pwr_ok, io_m_q};
        end
    end

    // power-on reset: released once both good, re-armed by core loss only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            por_done_q <= 1'b0;
        end else if (!core_s_q) begin
            por_done_q <= 1'b0;
        end else if (io_s_q) begin
            por_done_q <= 1'b1;
        end
    end

    // soft reset pulse and pin release while core is dark
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            soft_rst_q  <= 1'b0;
            link_oe_n_q <= 1'b1;
        end else begin
            soft_rst_q  <= wr_reset;
            link_oe_n_q <= !core_s_q;
        end
    end

    // ahb-lite slave: zero wait, always okay; bus state survives soft reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q        <= '0;
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b0;
            hresp_q     <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            if (hready) begin
                ph_q.valid <= addr_take;
                ph_q.write <= hwrite;
                ph_q.addr  <= {haddr[7:2], 2'h0};
            end
            if (addr_take && !hwrite) begin
                hrdata_q <= rd_data;
            end
        end
    end

    // control registers and deferred mode change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_meas_q <= `CTRL_RESET;
            ctrl_hum_q  <= `CTRL_RESET;
            config_q    <= `CTRL_RESET;
            mode_q      <= `MODE_SLEEP;
            pend_mode_q <= `MODE_SLEEP;
            pend_q      <= 1'b0;
            filt_init_q <= 2'h0;
        end else if (logic_rst) begin
            ctrl_meas_q <= `CTRL_RESET;
            ctrl_hum_q  <= `CTRL_RESET;
            config_q    <= `CTRL_RESET;
            mode_q      <= `MODE_SLEEP;
            pend_mode_q <= `MODE_SLEEP;
            pend_q      <= 1'b0;
            filt_init_q <= 2'h0;
        end else begin
            if (meas_take) begin
                ctrl_meas_q <= hwdata[7:0];
            end
            if (hum_take) begin
                ctrl_hum_q <= hwdata[7:0];
            end
            if (wr_cfg) begin
                config_q <= hwdata[7:0];
            end
            // per-channel seed flags, so a skipped channel never filters against an unseeded memory;
            // a config write wins over a seed in the same cycle
            if (wr_cfg) begin
                filt_init_q <= 2'h0;
            end else if (step_done && (state_q == sensor_mode_sequencer_pkg::ST_WAIT) && !last_ch) begin
                filt_init_q[ch_q[0]] <= 1'b1;
            end
            // mode: deferred while measuring, otherwise taken at once
            if (meas_take && measuring && !meas_end) begin
                pend_q      <= 1'b1;
                pend_mode_q <= wr_mode;
            end else if (meas_end) begin
                pend_q <= 1'b0;
                mode_q <= meas_take ? wr_mode : end_mode;
            end else if (meas_take) begin
                mode_q <= wr_mode;
            end
        end
    end

    // measurement sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= sensor_mode_sequencer_pkg::ST_SLEEP;
            ch_q     <= 2'h0;
            sb_cnt_q <= 12'h000;
            conv_q   <= '0;
        end else if (logic_rst) begin
            state_q  <= sensor_mode_sequencer_pkg::ST_SLEEP;
            ch_q     <= 2'h0;
            sb_cnt_q <= 12'h000;
            conv_q   <= '0;
        end else begin
            unique case (state_q)
                sensor_mode_sequencer_pkg::ST_SLEEP: begin
                    ch_q <= 2'h0;
                    if (mode_q != `MODE_SLEEP) begin
                        state_q <= sensor_mode_sequencer_pkg::ST_START;
                    end
                end
                sensor_mode_sequencer_pkg::ST_START: begin
                    if (osrs_cur != 3'h0) begin
                        conv_q.req  <= 1'b1;
                        conv_q.chan <= ch_q;
                        conv_q.osrs <= osrs_cur;
                        state_q     <= sensor_mode_sequencer_pkg::ST_WAIT;
                    end else if (!last_ch) begin
                        ch_q <= ch_q + 2'h1;
                    end
                end
                sensor_mode_sequencer_pkg::ST_WAIT: begin
                    if (rx_done) begin
                        conv_q.req <= 1'b0;
                        if (!last_ch) begin
                            ch_q    <= ch_q + 2'h1;
                            state_q <= sensor_mode_sequencer_pkg::ST_START;
                        end
                    end
                end
                sensor_mode_sequencer_pkg::ST_STANDBY: begin
                    if (mode_q != `MODE_NORMAL) begin
                        state_q <= sensor_mode_sequencer_pkg::ST_SLEEP;
                    end else if (sb_tick) begin
                        if (sb_cnt_q <= 12'h001) begin
                            ch_q    <= 2'h0;
                            state_q <= sensor_mode_sequencer_pkg::ST_START;
                        end else begin
                            sb_cnt_q <= sb_cnt_q - 12'h001;
                        end
                    end
                end
                default: state_q <= sensor_mode_sequencer_pkg::ST_SLEEP;
            endcase
            // end of period: standby in normal mode, else sleep
            if (meas_end) begin
                ch_q     <= 2'h0;
                sb_cnt_q <= sb_ticks(config_q[`CFG_STANDBY]);
                state_q  <= ((meas_take ? wr_mode : end_mode) == `MODE_NORMAL) ?
                            sensor_mode_sequencer_pkg::ST_STANDBY :
                            sensor_mode_sequencer_pkg::ST_SLEEP;
            end
        end
    end

    // half-millisecond tick divider, restarted at every standby entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= 32'h00000000;
        end else if (logic_rst || meas_end || sb_tick ||
                     (state_q != sensor_mode_sequencer_pkg::ST_STANDBY)) begin
            div_q <= 32'h00000000;
        end else begin
            div_q <= div_q + 32'h00000001;
        end
    end

    // result registers; they stay readable between periods
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_q      <= `SKIP_TP;
            press_q     <= `SKIP_TP;
            hum_q       <= `SKIP_H;
            temp_mem_q  <= 20'h00000;
            press_mem_q <= 20'h00000;
        end else if (logic_rst) begin
            temp_q      <= `SKIP_TP;
            press_q     <= `SKIP_TP;
            hum_q       <= `SKIP_H;
            temp_mem_q  <= 20'h00000;
            press_mem_q <= 20'h00000;
        end else if (step_done) begin
            if (state_q == sensor_mode_sequencer_pkg::ST_START) begin
                // skipped: marker out, filter memory kept
                unique case (ch_q)
                    2'h0:    temp_q  <= `SKIP_TP;
                    2'h1:    press_q <= `SKIP_TP;
                    default: hum_q   <= `SKIP_H;
                endcase
            end else begin
                unique case (ch_q)
                    2'h0: begin
                        temp_q     <= t_filt;
                        temp_mem_q <= t_filt;
                    end
                    2'h1: begin
                        press_q     <= p_filt;
                        press_mem_q <= p_filt;
                    end
                    default: hum_q <= rx_word[19:4];
                endcase
            end
        end
    end

    // serial result receiver
    sample_link_rx u_rx (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clear      (logic_rst),
        .start      (rx_start),
        .done_q     (rx_done),
        .word_q     (rx_word),
        .link_sclk  (link_sclk),
        .link_sdata (link_sdata)
    );

endmodule // sensor_mode_sequencer

// ---- dv/sensor_mode_sequencer_asserts.sv ----
// port assertions for the sensor mode sequencer
`timescale 1ns/1ps
module sensor_mode_sequencer_asserts (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched ports
    input wire logic hresp_q,
    input wire logic hreadyout_q,
    input wire logic core_pwr_ok,
    input wire logic link_oe_n_q,
    input wire sensor_mode_sequencer_pkg::conv_req_s conv_q
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // start of one conversion request
    sequence s_req;
        $rose(conv_q.req);
    endsequence
    property p_okay; hresp_q == 1'b0; endproperty
    property p_ready; $past(hresetn) |-> hreadyout_q; endproperty
    property p_hiz; !core_pwr_ok [*4] |=> link_oe_n_q; endproperty
    property p_chan; conv_q.req |-> conv_q.chan != 2'h3; endproperty
    property p_hold; conv_q.req && $past(conv_q.req) |-> $stable(conv_q); endproperty
    property p_skip; s_req |-> conv_q.osrs != 3'h0; endproperty
    property p_sleep; $rose(hresetn) |-> !conv_q.req [*8]; endproperty
    property p_reqlen; s_req |-> conv_q.req [*8]; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    a_ready: assert property (p_ready) else $error("wait state");
    a_hiz: assert property (p_hiz) else $error("pins driven");
    a_chan: assert property (p_chan) else $error("bad channel");
    a_hold: assert property (p_hold) else $error("request moved");
    a_skip: assert property (p_skip) else $error("skipped channel run");
    a_sleep: assert property (p_sleep) else $error("not asleep");
    a_reqlen: assert property (p_reqlen) else $error("short word");
endmodule // sensor_mode_sequencer_asserts

bind sensor_mode_sequencer sensor_mode_sequencer_asserts u_chk (
    .hclk(hclk), .hresetn(hresetn), .hresp_q(hresp_q), .hreadyout_q(hreadyout_q),
    .core_pwr_ok(core_pwr_ok), .link_oe_n_q(link_oe_n_q), .conv_q(conv_q)
);

// ---- dv/front_end_model.sv ----
// behavioural analog front end answering conversion requests
`timescale 1ns/1ps
module front_end_model (
    // request from the sequencer
    input wire sensor_mode_sequencer_pkg::conv_req_s conv_q,
    // serial link, clock still outside frames
    output logic link_sclk,
    output logic link_sdata
);
    logic [19:0] word_t;
    // one 20-bit word per request, msb first
    initial begin
        link_sclk = 1'b0;
        link_sdata = 1'b0;
        forever begin
            wait (conv_q.req === 1'b1);
            #10; // step off the clock edge before reading chan and osrs
            word_t = 20'h12345 + 20'h11111 * conv_q.chan + 20'h00100 * (conv_q.osrs - 3'h1);
            for (int i = 19; i >= 0; i--) begin
                link_sdata = word_t[i];
                #200 link_sclk = 1'b1;
                #200 link_sclk = 1'b0;
            end
            link_sdata = ~link_sdata; // no stale bit after release
            wait (conv_q.req !== 1'b1);
        end
    end
endmodule // front_end_model

// ---- dv/sensor_mode_sequencer_bench.sv ----
// self-checking bench for the sensor mode sequencer
`timescale 1ns/1ps
`include "sensor_mode_sequencer_cfg.svh"
module sensor_mode_sequencer_bench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        core_pwr_ok = 1'b1;
    logic        io_pwr_ok = 1'b0;
    logic [31:0] hrdata_q, rd;
    logic        hreadyout_q, hresp_q, link_oe_n_q, link_sclk, link_sdata;
    sensor_mode_sequencer_pkg::conv_req_s conv_q;
    int          n_mismatch = 0;
    int          total_checks = 0;
    realtime     t0;
    // small tick keeps standby waits short
    sensor_mode_sequencer #(.SB_TICK_CYCLES(4)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout_q), .hwdata(hwdata),
        .hrdata_q(hrdata_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
        .core_pwr_ok(core_pwr_ok), .io_pwr_ok(io_pwr_ok), .conv_q(conv_q),
        .link_oe_n_q(link_oe_n_q), .link_sclk(link_sclk), .link_sdata(link_sdata));
    front_end_model u_fe (.conv_q(conv_q), .link_sclk(link_sclk), .link_sdata(link_sdata));
    // 20 mhz clock
    initial begin
        forever #25 hclk = ~hclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", s, exp, seen);
        end
    endtask
    // one single transfer, address phase then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout_q !== 1'b1 && n < 99);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout_q !== 1'b1 && n < 99);
        rd = hrdata_q;
        if (n >= 99) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), rd, e);
    endtask
    // bounded poll of the measuring flag
    task automatic poll(input logic b);
        int k;
        k = 0;
        do begin
            bus(`OFS_STATUS, 1'b0, 32'h0);
            k++;
        end while (rd[`STATUS_BUSY] !== b && k < 900);
        if (k >= 900) begin
            n_mismatch++;
            end_sim();
        end
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(`OFS_CTRL_HUM, 1'b1, 32'h1);
        rc(`OFS_CTRL_HUM, 32'h0);
        io_pwr_ok <= 1'b1;
        repeat (6) @(posedge hclk);
        rc(`OFS_ID, {24'h0, `CHIP_ID_VAL});
        rc(8'h3c, 32'h0);
        rc(`OFS_CTRL_MEAS, 32'h0);
        rc(`OFS_TEMP, 32'h80000);
        bus(`OFS_CONFIG, 1'b1, 32'h20);
        bus(`OFS_CTRL_HUM, 1'b1, 32'h1);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h25);
        poll(1'b1);
        poll(1'b0);
        rc(`OFS_TEMP, 32'h12345);
        rc(`OFS_PRESS, 32'h23456);
        rc(`OFS_HUM, 32'h3456);
        rc(`OFS_CTRL_MEAS, 32'h24);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h06);
        poll(1'b1);
        poll(1'b0);
        rc(`OFS_TEMP, 32'h80000);
        repeat (300) @(posedge hclk);
        rc(`OFS_STATUS, 32'h0);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h27);
        poll(1'b1);
        poll(1'b0);
        t0 = $realtime;
        poll(1'b1);
        chk("standby", {31'h0, ($realtime - t0) >= 24500 && ($realtime - t0) <= 25800}, 32'h1);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h24);
        bus(`OFS_CTRL_HUM, 1'b1, 32'h0);
        rc(`OFS_CTRL_MEAS, 32'h27);
        poll(1'b0);
        rc(`OFS_CTRL_MEAS, 32'h24);
        rc(`OFS_CTRL_HUM, 32'h1);
        rc(`OFS_TEMP, 32'h12345);
        io_pwr_ok <= 1'b0;
        repeat (10) @(posedge hclk);
        io_pwr_ok <= 1'b1;
        repeat (6) @(posedge hclk);
        rc(`OFS_CTRL_HUM, 32'h1);
        bus(`OFS_CONFIG, 1'b1, 32'h04);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h25);
        poll(1'b1);
        poll(1'b0);
        bus(`OFS_CTRL_HUM, 1'b1, 32'h3);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h65);
        poll(1'b1);
        poll(1'b0);
        rc(`OFS_TEMP, 32'h12445);
        rc(`OFS_HUM, 32'h3476);
        bus(`OFS_CONFIG, 1'b1, 32'h04);
        bus(`OFS_CTRL_MEAS, 1'b1, 32'h25);
        poll(1'b1);
        poll(1'b0);
        rc(`OFS_TEMP, 32'h12345);
        bus(`OFS_RESET, 1'b1, 32'hb6);
        @(posedge hclk); // internal reset lands one cycle after the data phase
        rc(`OFS_CTRL_HUM, 32'h0);
        bus(`OFS_CTRL_HUM, 1'b1, 32'h1);
        core_pwr_ok <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("oe", {31'h0, link_oe_n_q}, 32'h1);
        core_pwr_ok <= 1'b1;
        repeat (8) @(posedge hclk);
        rc(`OFS_CTRL_HUM, 32'h0);
        end_sim();
    end
endmodule // sensor_mode_sequencer_bench
